// file: logic/pmic_im_map.vh
// Register map, field positions and reset values of the mask and status block
`ifndef PMIC_IM_MAP_VH
`define PMIC_IM_MAP_VH

`define PMIC_IM_OFS_STATUS      8'h28
`define PMIC_IM_OFS_MASK_A      8'h29
`define PMIC_IM_OFS_MASK_B      8'h2A
`define PMIC_IM_OFS_MASK_CONV   8'h2B
`define PMIC_IM_OFS_FLAG_A      8'h20
`define PMIC_IM_OFS_FLAG_B      8'h21
`define PMIC_IM_OFS_FLAG_CONV   8'h22

`define PMIC_IM_RST_MASK_A      8'h00
`define PMIC_IM_RST_MASK_B      8'h01
`define PMIC_IM_RST_MASK_CONV   8'h00
`define PMIC_IM_RST_FLAG        8'h00

`define PMIC_IM_STAT_MON_B      4
`define PMIC_IM_STAT_MON_A      2
`define PMIC_IM_STAT_ANALOG     0

`define PMIC_IM_A_LOAD_MEAS     7
`define PMIC_IM_A_SYNC_CLK      3
`define PMIC_IM_A_THERMAL       1
`define PMIC_IM_B_RESET_REG     0

`define PMIC_IM_C_B_PG_FALL     7
`define PMIC_IM_C_B_PG_RISE     6
`define PMIC_IM_C_B_ILIM        4
`define PMIC_IM_C_A_PG_FALL     3
`define PMIC_IM_C_A_PG_RISE     2
`define PMIC_IM_C_A_ILIM        0

`define PMIC_IM_DEV_ADDR        7'h60

`endif

// file: logic/pmic_im_sync.v
// Two-stage synchroniser for a group of asynchronous levels
`timescale 1ns/1ps
module pmic_im_sync
#(
   parameter WIDTH = 1
)
(
   input  wire             clk,
   input  wire             rstN,
   input  wire [WIDTH-1:0] asyncIn,
   output wire [WIDTH-1:0] syncOut
);
   reg [WIDTH-1:0] stage1_reg;
   reg [WIDTH-1:0] stage2_reg;

   always @(posedge clk or negedge rstN)
   begin
      if (!rstN)
      begin
         stage1_reg <= {WIDTH{1'b0}};
         stage2_reg <= {WIDTH{1'b0}};
      end
      else
      begin
         stage1_reg <= asyncIn;
         stage2_reg <= stage1_reg;
      end
   end

   assign syncOut = stage2_reg;
endmodule // pmic_im_sync

// file: logic/pmic_im_top.v
// Interrupt mask, event flag and input validity status block with serial slave
// Overview of operation
// - Status bit 4 follows the second monitor input validity live, unlatched.
// - Status bit 2 reports the first monitor input validity as raw status.
// - Status bit 0 reports the analog supply input validity as raw status.
// - Status bits are live comparator results, never sticky captures.
// - Mask A bit 7 set blocks the load measurement ready interrupt.
// - Mask A bit 3 set blocks the external clock detection interrupt.
// - Mask A bit 1 blocks thermal warning interrupt; live thermal bit unaffected.
// - Mask B bit 0 blocks register reset interrupt; async reset loads one, then the OTP value.
// - Converter mask bit 7 blocks converter B power-good fall interrupt.
// - Converter mask bit 6 blocks converter B power-good rise interrupt.
// - Converter mask bit 4 blocks converter B current-limit interrupt only.
// - Converter mask bit 3 blocks converter A power-good fall interrupt.
// - Converter mask bit 2 blocks converter A power-good rise interrupt.
// - Converter mask bit 0 blocks converter A current-limit interrupt only.
// - Power-good masks gate interrupts only, never the live power-good status.
// - Mask defaults after reset come from one-time-programmable configuration.
`timescale 1ns/1ps
`include "pmic_im_map.vh"
module pmic_im_top
#(
   parameter [6:0] DEV_ADDR = `PMIC_IM_DEV_ADDR
)
(
   input  wire       clk,
   input  wire       resetn,
   input  wire       scl,
   input  wire       sdaIn,
   output wire       sdaOut,
   output wire       sdaOe,
   input  wire       monitorInputA,
   input  wire       monitorInputB,
   input  wire       analogSupplyInput,
   input  wire       thermalWarningLive,
   input  wire       syncClockDetect,
   input  wire       convAPgLive,
   input  wire       convBPgLive,
   input  wire       convACurrentLimitLive,
   input  wire       convBCurrentLimitLive,
   input  wire       loadMeasReady,
   input  wire       registerResetEvent,
   input  wire [7:0] otpMaskA,
   input  wire [7:0] otpMaskB,
   input  wire [7:0] otpMaskConv,
   output wire       intReqN
);
   localparam [3:0] ST_IDLE    = 4'h0;
   localparam [3:0] ST_DEV     = 4'h1;
   localparam [3:0] ST_DEV_ACK = 4'h2;
   localparam [3:0] ST_REG     = 4'h3;
   localparam [3:0] ST_REG_ACK = 4'h4;
   localparam [3:0] ST_WR      = 4'h5;
   localparam [3:0] ST_WR_ACK  = 4'h6;
   localparam [3:0] ST_RD      = 4'h7;
   localparam [3:0] ST_RD_ACK  = 4'h8;

   reg  [1:0] rstPipe_reg;
   wire       rstN;
   wire [1:0] busSync;
   wire [8:0] lvlSync;
   reg  [1:0] busPrev_reg;
   reg  [8:0] lvlPrev_reg;
   reg  [1:0] lvlPrime_reg;
   reg  [7:0] maskA_reg;
   reg  [7:0] maskB_reg;
   reg  [7:0] maskConv_reg;
   reg        otpDone_reg;
   reg  [7:0] flagA_reg;
   reg  [7:0] flagA_next;
   reg  [7:0] flagB_reg;
   reg  [7:0] flagB_next;
   reg  [7:0] flagConv_reg;
   reg  [7:0] flagConv_next;
   reg        intReqN_reg;
   reg  [3:0] state_reg;
   reg  [7:0] shift_reg;
   reg  [7:0] tx_reg;
   reg  [3:0] bitCnt_reg;
   reg  [7:0] ptr_reg;
   reg        readMode_reg;
   reg        masterAck_reg;
   reg        sdaOe_reg;
   reg        wrStrobe;
   reg  [7:0] rdData;
   reg  [7:0] setA;
   reg  [7:0] setB;
   reg  [7:0] setConv;
   wire       sclS;
   wire       sdaS;
   wire       sclRise;
   wire       sclFall;
   wire       busStart;
   wire       busStop;
   wire [7:0] statusWord;
   wire [8:0] lvlRise;
   wire [8:0] lvlFall;
   wire       lvlPrimed;

   // Reset release through two flops; assertion stays asynchronous
   always @(posedge clk or negedge resetn)
   begin
      if (!resetn)
         rstPipe_reg <= 2'b00;
      else
         rstPipe_reg <= {rstPipe_reg[0], 1'b1};
   end
   assign rstN = rstPipe_reg[1];

   pmic_im_sync #(.WIDTH(2)) u_busSync
   (
      .clk     (clk),
      .rstN    (rstN),
      .asyncIn ({scl, sdaIn}),
      .syncOut (busSync)
   );

   pmic_im_sync #(.WIDTH(9)) u_lvlSync
   (
      .clk     (clk),
      .rstN    (rstN),
      .asyncIn ({convBCurrentLimitLive, convACurrentLimitLive, convBPgLive, convAPgLive,
                 syncClockDetect, thermalWarningLive, analogSupplyInput, monitorInputA,
                 monitorInputB}),
      .syncOut (lvlSync)
   );

   assign sclS     = busSync[1];
   assign sdaS     = busSync[0];
   assign sclRise  = sclS & ~busPrev_reg[1];
   assign sclFall  = ~sclS & busPrev_reg[1];
   assign busStart = sclS & busPrev_reg[1] & ~sdaS & busPrev_reg[0];
   assign busStop  = sclS & busPrev_reg[1] & sdaS & ~busPrev_reg[0];

   // Synchroniser restarts from zero, so a level held high through reset
   // would look like a rising edge; edges wait until both samples are real
   assign lvlPrimed = &lvlPrime_reg;
   assign lvlRise = lvlPrimed ? (lvlSync & ~lvlPrev_reg) : 9'h000;
   assign lvlFall = lvlPrimed ? (~lvlSync & lvlPrev_reg) : 9'h000;

   always @(posedge clk or negedge rstN)
   begin
      if (!rstN)
      begin
         busPrev_reg   <= 2'b11;
         lvlPrev_reg   <= 9'h000;
         lvlPrime_reg  <= 2'b00;
      end
      else
      begin
         busPrev_reg   <= busSync;
         lvlPrev_reg   <= lvlSync;
         if (!lvlPrimed)
            lvlPrime_reg <= lvlPrime_reg + 2'b01;
      end
   end

   // Live status, no capture stage between comparator and read path
   assign statusWord = {3'b000,
                        lvlSync[0],
                        1'b0,
                        lvlSync[1],
                        1'b0,
                        lvlSync[2]};

   always @*
   begin
      setA = 8'h00;
      setB = 8'h00;
      setConv = 8'h00;
      setA[`PMIC_IM_A_LOAD_MEAS] = loadMeasReady & ~maskA_reg[`PMIC_IM_A_LOAD_MEAS];
      setA[`PMIC_IM_A_SYNC_CLK]  = lvlRise[4] & ~maskA_reg[`PMIC_IM_A_SYNC_CLK];
      setA[`PMIC_IM_A_THERMAL]   = lvlRise[3] & ~maskA_reg[`PMIC_IM_A_THERMAL];
      setB[`PMIC_IM_B_RESET_REG] = registerResetEvent
                                   & ~maskB_reg[`PMIC_IM_B_RESET_REG];
      setConv[`PMIC_IM_C_B_PG_RISE] = (lvlFall[6] & ~maskConv_reg[`PMIC_IM_C_B_PG_FALL])
                                    | (lvlRise[6] & ~maskConv_reg[`PMIC_IM_C_B_PG_RISE]);
      setConv[`PMIC_IM_C_B_ILIM] = lvlRise[8] & ~maskConv_reg[`PMIC_IM_C_B_ILIM];
      setConv[`PMIC_IM_C_A_PG_RISE] = (lvlFall[5] & ~maskConv_reg[`PMIC_IM_C_A_PG_FALL])
                                    | (lvlRise[5] & ~maskConv_reg[`PMIC_IM_C_A_PG_RISE]);
      setConv[`PMIC_IM_C_A_ILIM] = lvlRise[7] & ~maskConv_reg[`PMIC_IM_C_A_ILIM];
   end

   function [7:0] readMux;
      input [7:0] addr;
      begin
         case (addr)
            `PMIC_IM_OFS_STATUS:    readMux = statusWord;
            `PMIC_IM_OFS_MASK_A:    readMux = maskA_reg;
            `PMIC_IM_OFS_MASK_B:    readMux = maskB_reg;
            `PMIC_IM_OFS_MASK_CONV: readMux = maskConv_reg;
            `PMIC_IM_OFS_FLAG_A:    readMux = flagA_reg;
            `PMIC_IM_OFS_FLAG_B:    readMux = flagB_reg;
            `PMIC_IM_OFS_FLAG_CONV: readMux = flagConv_reg;
            default:                readMux = 8'h00;
         endcase
      end
   endfunction

   always @*
   begin
      rdData = readMux(ptr_reg);
      wrStrobe = (state_reg == ST_WR) && sclFall && (bitCnt_reg == 4'h8) && !busStart
                 && !busStop;
   end

   // Write-one-to-clear; a same-cycle event keeps its flag set
   always @*
   begin
      flagA_next    = flagA_reg | setA;
      flagB_next    = flagB_reg | setB;
      flagConv_next = flagConv_reg | setConv;
      if (wrStrobe && ptr_reg == `PMIC_IM_OFS_FLAG_A)
         flagA_next = (flagA_reg & ~shift_reg) | setA;
      if (wrStrobe && ptr_reg == `PMIC_IM_OFS_FLAG_B)
         flagB_next = (flagB_reg & ~shift_reg) | setB;
      if (wrStrobe && ptr_reg == `PMIC_IM_OFS_FLAG_CONV)
         flagConv_next = (flagConv_reg & ~shift_reg) | setConv;
   end

   always @(posedge clk or negedge rstN)
   begin
      if (!rstN)
      begin
         flagA_reg    <= `PMIC_IM_RST_FLAG;
         flagB_reg    <= `PMIC_IM_RST_FLAG;
         flagConv_reg <= `PMIC_IM_RST_FLAG;
         intReqN_reg  <= 1'b1;
      end
      else
      begin
         flagA_reg    <= flagA_next;
         flagB_reg    <= flagB_next;
         flagConv_reg <= flagConv_next;
         intReqN_reg  <= ~(|flagA_next | |flagB_next | |flagConv_next);
      end
   end

   // OTP defaults land one cycle after release; async reset only takes constants
   always @(posedge clk or negedge rstN)
   begin
      if (!rstN)
      begin
         maskA_reg    <= `PMIC_IM_RST_MASK_A;
         maskB_reg    <= `PMIC_IM_RST_MASK_B;
         maskConv_reg <= `PMIC_IM_RST_MASK_CONV;
         otpDone_reg  <= 1'b0;
      end
      else if (!otpDone_reg)
      begin
         maskA_reg    <= otpMaskA;
         maskB_reg    <= otpMaskB;
         maskConv_reg <= otpMaskConv;
         otpDone_reg  <= 1'b1;
      end
      else if (wrStrobe)
      begin
         // All eight bits stored, reserved ones included
         if (ptr_reg == `PMIC_IM_OFS_MASK_A)
            maskA_reg <= shift_reg;
         if (ptr_reg == `PMIC_IM_OFS_MASK_B)
            maskB_reg <= shift_reg;
         if (ptr_reg == `PMIC_IM_OFS_MASK_CONV)
            maskConv_reg <= shift_reg;
      end
   end

   // Serial slave: start/stop take priority over bit handling
   always @(posedge clk or negedge rstN)
   begin
      if (!rstN)
      begin
         state_reg     <= ST_IDLE;
         shift_reg     <= 8'h00;
         tx_reg        <= 8'h00;
         bitCnt_reg    <= 4'h0;
         ptr_reg       <= 8'h00;
         readMode_reg  <= 1'b0;
         masterAck_reg <= 1'b0;
         sdaOe_reg     <= 1'b0;
      end
      else if (busStart)
      begin
         state_reg  <= ST_DEV;
         bitCnt_reg <= 4'h0;
         sdaOe_reg  <= 1'b0;
      end
      else if (busStop)
      begin
         state_reg <= ST_IDLE;
         sdaOe_reg <= 1'b0;
      end
      else
      begin
         case (state_reg)
            ST_IDLE:
               sdaOe_reg <= 1'b0;
            ST_DEV, ST_REG, ST_WR:
            begin
               if (sclRise && bitCnt_reg != 4'h8)
               begin
                  shift_reg  <= {shift_reg[6:0], sdaS};
                  bitCnt_reg <= bitCnt_reg + 4'h1;
               end
               else if (sclFall && bitCnt_reg == 4'h8)
               begin
                  bitCnt_reg <= 4'h0;
                  if (state_reg == ST_DEV)
                  begin
                     if (shift_reg[7:1] == DEV_ADDR)
                     begin
                        readMode_reg <= shift_reg[0];
                        sdaOe_reg    <= 1'b1;
                        state_reg    <= ST_DEV_ACK;
                     end
                     else
                        state_reg <= ST_IDLE;
                  end
                  else if (state_reg == ST_REG)
                  begin
                     ptr_reg   <= shift_reg;
                     sdaOe_reg <= 1'b1;
                     state_reg <= ST_REG_ACK;
                  end
                  else
                  begin
                     sdaOe_reg <= 1'b1;
                     state_reg <= ST_WR_ACK;
                  end
               end
            end
            ST_DEV_ACK, ST_REG_ACK, ST_WR_ACK:
            begin
               if (sclFall)
               begin
                  bitCnt_reg <= 4'h0;
                  if (state_reg == ST_WR_ACK)
                     ptr_reg <= ptr_reg + 8'h01;
                  if (state_reg == ST_DEV_ACK && readMode_reg)
                  begin
                     tx_reg    <= rdData;
                     sdaOe_reg <= ~rdData[7];
                     state_reg <= ST_RD;
                  end
                  else
                  begin
                     sdaOe_reg <= 1'b0;
                     state_reg <= (state_reg == ST_DEV_ACK) ? ST_REG : ST_WR;
                  end
               end
            end
            ST_RD:
            begin
               if (sclFall)
               begin
                  if (bitCnt_reg == 4'h7)
                  begin
                     sdaOe_reg <= 1'b0;
                     ptr_reg   <= ptr_reg + 8'h01;
                     state_reg <= ST_RD_ACK;
                  end
                  else
                  begin
                     tx_reg     <= {tx_reg[6:0], 1'b0};
                     sdaOe_reg  <= ~tx_reg[6];
                     bitCnt_reg <= bitCnt_reg + 4'h1;
                  end
               end
            end
            ST_RD_ACK:
            begin
               if (sclRise)
                  masterAck_reg <= ~sdaS;
               else if (sclFall)
               begin
                  bitCnt_reg <= 4'h0;
                  if (masterAck_reg)
                  begin
                     // Pointer already advanced, so rdData is the next byte
                     tx_reg    <= rdData;
                     sdaOe_reg <= ~rdData[7];
                     state_reg <= ST_RD;
                  end
                  else
                     state_reg <= ST_IDLE;
               end
            end
            default:
               state_reg <= ST_IDLE;
         endcase
      end
   end

   // Open drain: only ever pulls low
   assign sdaOut  = 1'b0;
   assign sdaOe   = sdaOe_reg;
   assign intReqN = intReqN_reg;
endmodule // pmic_im_top

// file: tb/pmic_im_monitor.sv
// Port-level checker for the mask, flag and interrupt block
`timescale 1ns/1ps
module pmic_im_monitor
(
   input logic       clk,
   input logic       resetn,
   input logic       scl,
   input logic       sdaOe,
   input logic       intReqN,
   input logic       thermalWarningLive,
   input logic       syncClockDetect,
   input logic       convAPgLive,
   input logic       convBPgLive,
   input logic       convACurrentLimitLive,
   input logic       convBCurrentLimitLive,
   input logic       loadMeasReady,
   input logic       registerResetEvent,
   input logic [7:0] otpMaskA,
   input logic [7:0] otpMaskB,
   input logic [7:0] otpMaskConv
);
   logic [5:0] liveVec;
   logic [5:0] liveQ;
   logic [3:0] sinceEvent;
   logic [2:0] sinceRst;
   logic       busSeen;
   logic       quiet;

   assign liveVec = {thermalWarningLive, syncClockDetect, convAPgLive, convBPgLive,
                     convACurrentLimitLive, convBCurrentLimitLive};
   // Masks equal the OTP inputs only until the first bus transfer
   assign quiet   = (sinceRst == 3'h7) && !busSeen;

   always @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         liveQ      <= 6'h00;
         sinceEvent <= 4'hF;
         sinceRst   <= 3'h0;
         busSeen    <= 1'b0;
      end
      else
      begin
         liveQ <= liveVec;
         if (loadMeasReady || registerResetEvent || (liveVec != liveQ))
            sinceEvent <= 4'h0;
         else if (sinceEvent != 4'hF)
            sinceEvent <= sinceEvent + 4'h1;
         if (sinceRst != 3'h7)
            sinceRst <= sinceRst + 3'h1;
         if (!scl)
            busSeen <= 1'b1;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);

   chk_reset_idle : assert property ($rose(resetn) |-> intReqN && !sdaOe)
      else $error("interrupt or data pin active out of reset");
   chk_all_masked : assert property (!busSeen && ((otpMaskA & otpMaskB & otpMaskConv) == 8'hFF)
      |-> intReqN)
      else $error("interrupt raised with every mask set");
   chk_load_raise : assert property (quiet && loadMeasReady && !otpMaskA[7] |=> !intReqN)
      else $error("unmasked load measurement event gave no interrupt");
   chk_thermal_raise : assert property (quiet && $rose(thermalWarningLive) && !otpMaskA[1]
      |-> ##[1:8] !intReqN)
      else $error("unmasked thermal warning gave no interrupt");
   chk_reg_reset_raise : assert property (quiet && registerResetEvent && !otpMaskB[0]
      |=> !intReqN)
      else $error("unmasked register reset event gave no interrupt");
   chk_flag_sticky : assert property (!intReqN && !busSeen |=> !intReqN)
      else $error("interrupt released without a host clear");
   chk_clear_by_ack : assert property ($rose(intReqN) |-> ##[0:8] sdaOe)
      else $error("interrupt released away from a bus write");
   chk_raise_cause : assert property ($fell(intReqN) |-> sinceEvent <= 4'h8)
      else $error("interrupt raised with no recent event");

   cover property (quiet && loadMeasReady && !otpMaskA[7]);
   cover property ($rose(intReqN));
   cover property ($fell(intReqN) && busSeen);
endmodule // pmic_im_monitor

// file: tb/pmic_im_host.sv
// Serial bus host model that reaches the device registers
`timescale 1ns/1ps
`include "pmic_im_map.vh"
module pmic_im_host
(
   input  logic clk,
   input  logic sdaLine,
   output logic scl,
   output logic sdaHost
);
   initial
   begin
      scl     = 1'b1;
      sdaHost = 1'b1;
   end

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   // Data moves only well inside the low phase, clear of both clock edges
   task automatic bit_io(input logic b, output logic r);
      tick(3);
      sdaHost = b;
      tick(10);
      scl = 1'b1;
      tick(10);
      r = sdaLine;
      scl = 1'b0;
   endtask

   task automatic start;
      tick(3);
      sdaHost = 1'b1;
      tick(10);
      scl = 1'b1;
      tick(10);
      sdaHost = 1'b0;
      tick(10);
      scl = 1'b0;
   endtask

   task automatic stop;
      tick(3);
      sdaHost = 1'b0;
      tick(10);
      scl = 1'b1;
      tick(10);
      sdaHost = 1'b1;
      tick(10);
   endtask

   task automatic byte_io(input logic [7:0] d, input logic ackIn, output logic [7:0] q,
                          output logic nak);
      for (int i = 7; i >= 0; i--)
         bit_io(d[i], q[i]);
      bit_io(ackIn, nak);
   endtask

   task automatic reg_write(input logic [7:0] addr, input logic [7:0] data, output logic nak);
      logic [7:0] q;
      logic [2:0] n;
      start;
      byte_io({`PMIC_IM_DEV_ADDR, 1'b0}, 1'b1, q, n[0]);
      byte_io(addr, 1'b1, q, n[1]);
      byte_io(data, 1'b1, q, n[2]);
      stop;
      nak = |n;
   endtask

   // Single byte read, closed with a NACK so the device lets go of the line
   task automatic reg_read(input logic [7:0] addr, output logic [7:0] data, output logic nak);
      logic [7:0] q;
      logic [2:0] n;
      logic       last;
      start;
      byte_io({`PMIC_IM_DEV_ADDR, 1'b0}, 1'b1, q, n[0]);
      byte_io(addr, 1'b1, q, n[1]);
      start;
      byte_io({`PMIC_IM_DEV_ADDR, 1'b1}, 1'b1, q, n[2]);
      byte_io(8'hFF, 1'b1, data, last);
      stop;
      nak = |n;
   endtask

   // Two-byte read: the first byte is ACKed, so the pointer has to advance
   task automatic reg_read2(input logic [7:0] addr, output logic [15:0] data,
                            output logic nak);
      logic [7:0] q;
      logic [2:0] n;
      logic       last;
      start;
      byte_io({`PMIC_IM_DEV_ADDR, 1'b0}, 1'b1, q, n[0]);
      byte_io(addr, 1'b1, q, n[1]);
      start;
      byte_io({`PMIC_IM_DEV_ADDR, 1'b1}, 1'b1, q, n[2]);
      byte_io(8'hFF, 1'b0, data[15:8], last);
      byte_io(8'hFF, 1'b1, data[7:0], last);
      stop;
      nak = |n;
   endtask
endmodule // pmic_im_host

// file: tb/pmic_im_test.sv
// Self-checking bench for the mask, flag and status block
`timescale 1ns/1ps
`include "pmic_im_map.vh"
module pmic_im_test;
   logic       clk;
   logic       resetn;
   logic       scl;
   logic       sdaHost;
   logic       sdaLine;
   logic       sdaOut;
   logic       sdaOe;
   logic       monitorInputA;
   logic       monitorInputB;
   logic       analogSupplyInput;
   logic       thermalWarningLive;
   logic       syncClockDetect;
   logic       convAPgLive;
   logic       convBPgLive;
   logic       convACurrentLimitLive;
   logic       convBCurrentLimitLive;
   logic       loadMeasReady;
   logic       registerResetEvent;
   logic [7:0] otpMaskA;
   logic [7:0] otpMaskB;
   logic [7:0] otpMaskConv;
   logic       intReqN;
   int         n_errors;
   int         num_checks;
   // Events: load, clock, thermal, reg reset, B fall, B rise, B ilim, A fall, A rise, A ilim
   localparam int FLAG_BIT [10] = '{7, 3, 1, 0, 6, 6, 4, 2, 2, 0};
   localparam int MASK_BIT [10] = '{7, 3, 1, 0, 7, 6, 4, 3, 2, 0};
   localparam int GROUP    [10] = '{0, 0, 0, 1, 2, 2, 2, 2, 2, 2};
   localparam int POST     [10] = '{1, 1, 1, 1, 0, 1, 1, 0, 1, 1};

   // Open drain line with pull-up
   assign sdaLine = sdaHost & (sdaOe ? sdaOut : 1'b1);

   pmic_im_top i_pmic_im_top
   (
      .clk, .resetn, .scl, .sdaIn(sdaLine), .sdaOut, .sdaOe, .monitorInputA, .monitorInputB,
      .analogSupplyInput, .thermalWarningLive, .syncClockDetect, .convAPgLive, .convBPgLive,
      .convACurrentLimitLive, .convBCurrentLimitLive, .loadMeasReady, .registerResetEvent,
      .otpMaskA, .otpMaskB, .otpMaskConv, .intReqN
   );

   pmic_im_host i_pmic_im_host (.clk, .sdaLine, .scl, .sdaHost);

   initial clk = 1'b0;
   always #5 clk = ~clk;

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic check_reg(input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         n_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic check_pin(input logic got, input logic exp);
      check_reg({7'h00, got}, {7'h00, exp});
   endtask

   task automatic wr(input logic [7:0] addr, input logic [7:0] data);
      logic nak;
      i_pmic_im_host.reg_write(addr, data, nak);
      check_pin(nak, 1'b0);
   endtask

   task automatic rd(input logic [7:0] addr, input logic [7:0] exp);
      logic [7:0] data;
      logic       nak;
      i_pmic_im_host.reg_read(addr, data, nak);
      check_pin(nak, 1'b0);
      check_reg(data, exp);
   endtask

   task automatic rd2(input logic [7:0] addr, input logic [15:0] exp);
      logic [15:0] data;
      logic        nak;
      i_pmic_im_host.reg_read2(addr, data, nak);
      check_pin(nak, 1'b0);
      check_reg(data[15:8], exp[15:8]);
      check_reg(data[7:0], exp[7:0]);
   endtask

   task automatic set_lvl(input int i, input logic v);
      case (i)
         1: syncClockDetect = v;
         2: thermalWarningLive = v;
         4, 5: convBPgLive = v;
         6: convBCurrentLimitLive = v;
         7, 8: convAPgLive = v;
         9: convACurrentLimitLive = v;
         default: ;
      endcase
   endtask

   // Level events first go to the opposite level so the edge is a clean one
   task automatic fire(input int i);
      set_lvl(i, POST[i] == 0);
      tick(8);
      loadMeasReady = (i == 0);
      registerResetEvent = (i == 3);
      set_lvl(i, POST[i] == 1);
      tick(1);
      loadMeasReady = 1'b0;
      registerResetEvent = 1'b0;
      tick(8);
   endtask

   task automatic do_reset(input logic [7:0] a, input logic [7:0] b, input logic [7:0] c);
      resetn = 1'b0;
      otpMaskA = a;
      otpMaskB = b;
      otpMaskConv = c;
      tick(8);
      resetn = 1'b1;
      tick(8);
   endtask

   task automatic complete_run;
      if (n_errors == 0 && num_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   initial
   begin
      {resetn, loadMeasReady, registerResetEvent, thermalWarningLive, syncClockDetect} = '0;
      {convAPgLive, convBPgLive, convACurrentLimitLive, convBCurrentLimitLive} = '0;
      {monitorInputA, monitorInputB, analogSupplyInput} = '0;
      n_errors = 0;
      num_checks = 0;
      do_reset(8'hFF, 8'hFF, 8'hFF);
      for (int i = 0; i < 10; i++)
         fire(i);
      check_pin(intReqN, 1'b1);
      for (int g = 0; g < 3; g++)
      begin
         rd(8'(`PMIC_IM_OFS_MASK_A + g), 8'hFF);
         rd(8'(`PMIC_IM_OFS_FLAG_A + g), 8'h00);
      end
      for (int i = 0; i < 10; i++)
      begin
         wr(8'(`PMIC_IM_OFS_MASK_A + GROUP[i]), ~(8'h01 << MASK_BIT[i]));
         fire(i);
         check_pin(intReqN, 1'b0);
         rd(8'(`PMIC_IM_OFS_FLAG_A + GROUP[i]), 8'h01 << FLAG_BIT[i]);
         wr(8'(`PMIC_IM_OFS_FLAG_A + GROUP[i]), 8'h01 << FLAG_BIT[i]);
         check_pin(intReqN, 1'b1);
         wr(8'(`PMIC_IM_OFS_MASK_A + GROUP[i]), 8'hFF);
      end
      wr(`PMIC_IM_OFS_STATUS, 8'hFF);
      for (int i = 0; i < 8; i += 3)
      begin
         {monitorInputB, monitorInputA, analogSupplyInput} = i[2:0];
         tick(8);
         rd(`PMIC_IM_OFS_STATUS, {3'h0, i[2], 1'b0, i[1], 1'b0, i[0]});
      end
      wr(`PMIC_IM_OFS_MASK_B, 8'hA4);
      rd(`PMIC_IM_OFS_MASK_B, 8'hA4);
      rd2(`PMIC_IM_OFS_MASK_B, 16'hA4FF);
      rd(8'h30, 8'h00);
      // Second reset with other OTP defaults, events before any bus traffic
      thermalWarningLive = 1'b0;
      do_reset(8'h74, 8'h00, 8'h22);
      thermalWarningLive = 1'b1;
      tick(8);
      check_pin(intReqN, 1'b0);
      fire(0);
      fire(3);
      rd(`PMIC_IM_OFS_FLAG_A, 8'h82);
      rd(`PMIC_IM_OFS_FLAG_B, 8'h01);
      rd(`PMIC_IM_OFS_MASK_A, 8'h74);
      rd(`PMIC_IM_OFS_MASK_B, 8'h00);
      rd(`PMIC_IM_OFS_MASK_CONV, 8'h22);
      complete_run;
   end

   initial
   begin
      #1_000_000;
      n_errors++;
      complete_run;
   end
endmodule // pmic_im_test

bind pmic_im_top pmic_im_monitor i_pmic_im_monitor
(
   .clk, .resetn, .scl, .sdaOe, .intReqN, .thermalWarningLive, .syncClockDetect, .convAPgLive,
   .convBPgLive, .convACurrentLimitLive, .convBCurrentLimitLive, .loadMeasReady,
   .registerResetEvent, .otpMaskA, .otpMaskB, .otpMaskConv
);
